// ---- special_instruction_unit.sv ----
/*
 * Top of the special instruction unit: fetch sequencer toward an external
 * program store, program counter with a three-level return stack, and the
 * unusual instructions of the 4-bit core.
 * Assumes clk_i is the 20 MHz oscillator, an external address latch and
 * memory on the multiplexed port, and same-clock logic for the RAM operand
 * and the carry flag.
 */
`timescale 1ns/1ps
`include "sic_cfg.svh"

module special_instruction_unit (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic [7:0]        rom_ad_i,
   output logic      [7:0]        rom_ad_o,
   output logic                   rom_ad_oe_o,
   output logic                   addr_phase_o,
   output logic      [2:0]        rom_addr_hi_o,
   input  wire logic [3:0]        in_pins_i,
   input  wire logic              si_i,
   output logic                   so_o,
   output logic                   logic_clock_out_o,
   input  wire sic_pkg::nibble_t  ram_operand_i,
   input  wire logic              carry_i,
   output sic_pkg::nibble_t       acc_o,
   output sic_pkg::nibble_t       enable_o,
   output logic      [7:0]        q_o,
   output sic_pkg::rom_addr_t     program_counter_o,
   output logic                   skip_o
);
   import sic_pkg::*;

   // ------------------------------------------------------------
   // Shared timing and pin synchronisers
   // ------------------------------------------------------------
   tick_if tick ();

   timebase_gen u_timebase (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .tick     (tick.src)
   );

   logic [7:0] ad_s1;
   logic [7:0] ad_s2;
   logic [3:0] in_s1;
   logic [3:0] in_s2;
   logic       si_s1;
   logic       si_s2;
   logic       si_prev;

   // Every pin passes two flops; only the second stage is decoded, except si, whose third flop feeds the falling-edge detect.
   always_ff @(posedge clk_i) begin
      ad_s1   <= rom_ad_i;
      ad_s2   <= ad_s1;
      in_s1   <= in_pins_i;
      in_s2   <= in_s1;
      si_s1   <= si_i;
      si_s2   <= si_s1;
      si_prev <= si_s2;
   end

   wire       instr_end = tick.instr_end;
   wire [7:0] data_byte = ad_s2;
   wire       si_fall   = si_prev & ~si_s2;

   // ------------------------------------------------------------
   // Architectural state
   // ------------------------------------------------------------
   core_state_e state_reg;
   core_state_e state_next;
   logic [7:0]  opc_reg;
   rom_addr_t   pc_reg;
   rom_addr_t   pc_next;
   rom_addr_t   fetch_reg;
   rom_addr_t   fetch_next;
   rom_addr_t   sa_reg;
   rom_addr_t   sb_reg;
   rom_addr_t   sc_reg;
   nibble_t     acc_reg;
   nibble_t     acc_next;
   nibble_t     en_reg;
   nibble_t     sio_reg;
   nibble_t     sio_next;
   logic [7:0]  q_reg;
   logic        table_load_op_mode_reg;
   logic        skl_reg;
   logic        sk_reg;
   logic        so_reg;
   logic        tb_flag_reg;
   logic        skip_reg;
   logic        skip_next;
   logic        addr_phase_reg;
   logic [1:0]  il_w;

   // ------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------
   wire in_fetch = (state_reg == ST_FETCH);
   wire in_oper  = (state_reg == ST_OPERAND);
   wire in_ind   = (state_reg == ST_INDIRECT);

   // Prefixed and long-jump opcodes carry a second byte that a skip must also eat.
   wire two_byte = (data_byte == `OP_PFX_IO) | (data_byte == `OP_PFX_RAM) |
                   (data_byte[7:4] == `OP_JMP_HI);
   wire f_run    = instr_end & in_fetch & ~skip_reg;
   wire o_run    = instr_end & in_oper & ~skip_reg;
   wire skip_eat = instr_end & skip_reg & ~(in_fetch & two_byte);

   wire do_clear_acc_op  = f_run & (data_byte == `OP_CLEAR_ACC_OP);
   wire do_skt   = f_run & (data_byte == `OP_SKT);
   wire do_retsk = f_run & (data_byte == `OP_RETSK);
   wire do_ret   = f_run & (data_byte == `OP_RET) | do_retsk;
   wire do_xas   = f_run & (data_byte == `OP_XAS);
   wire do_jid   = f_run & (data_byte == `OP_JID);
   wire do_table_load_op  = f_run & (data_byte == `OP_TABLE_LOAD_OP);
   wire do_subpage_call_op  = f_run & (data_byte[7:6] == `OP_SUBPAGE_CALL_OP_HI) & (data_byte != `OP_TABLE_LOAD_OP);
   wire do_jp    = f_run & (data_byte[7:6] == `OP_JP_HI) & (data_byte != `OP_JID);
   wire io_pfx   = o_run & (opc_reg == `OP_PFX_IO);
   wire do_lei   = io_pfx & (data_byte[7:4] == `OP2_LEI_HI);
   wire do_read_inputs_op  = io_pfx & (data_byte == `OP2_READ_INPUTS_OP);
   wire do_read_edge_latches_op  = io_pfx & (data_byte == `OP2_READ_EDGE_LATCHES_OP);
   wire do_jmp   = o_run & (opc_reg[7:4] == `OP_JMP_HI);
   wire do_jsr   = do_jmp & opc_reg[3];
   wire jid_end  = instr_end & in_ind & ~table_load_op_mode_reg;
   wire table_load_op_end = instr_end & in_ind & table_load_op_mode_reg;
   wire do_push  = do_subpage_call_op | do_jsr | do_table_load_op;
   wire do_pop   = do_ret | table_load_op_end;

   // ------------------------------------------------------------
   // Address arithmetic
   // ------------------------------------------------------------
   // The incremented counter pc_inc is past the current word, so page-relative targets
   // taken from it follow into the next page when the opcode sits last.
   wire rom_addr_t pc_inc   = pc_reg + 11'h001;
   wire rom_addr_t ind_addr = {pc_inc[10:8], acc_reg, ram_operand_i};
   wire            twin_pg  = (pc_inc[10:7] == `TWIN_PAGE_HI);
   wire rom_addr_t jp_addr  = twin_pg ? {pc_inc[10:7], data_byte[6:0]}
                                      : {pc_inc[10:6], data_byte[5:0]};

   // Priority order: indirect completion, returns, the first-cycle jumps, then the long jump.
   assign pc_next = jid_end ? {pc_reg[10:8], data_byte} :
                    do_pop  ? sa_reg :
                    do_table_load_op ? ind_addr :
                    do_subpage_call_op ? {`SUBPAGE_HI, data_byte[5:0]} :
                    do_jp   ? jp_addr :
                    do_jmp  ? {opc_reg[2:0], data_byte} :
                    pc_inc;

   // An indirect jump fetches its pointer byte while the counter only steps.
   assign fetch_next = do_jid ? ind_addr : pc_next;

   // ------------------------------------------------------------
   // Data paths
   // ------------------------------------------------------------
   assign acc_next = do_clear_acc_op ? `NIB_RESET :
                     do_xas  ? sio_reg :
                     do_read_inputs_op ? in_s2 :
                     do_read_edge_latches_op ? {il_w[1], `READ_EDGE_LATCHES_OP_FILL, il_w[0]} :
                     acc_reg;

   wire nibble_t sio_shift = {sio_reg[2:0], si_s2};
   wire nibble_t sio_count = sio_reg + 4'h1;
   wire          shift_md  = en_reg[`EN_SHIFT_BIT];

   // In shift mode one bit moves per instruction, so four cycles fill it.
   assign sio_next = do_xas   ? acc_reg :
                     shift_md ? (instr_end ? sio_shift : sio_reg) :
                     (si_fall ? sio_count : sio_reg);

   // A fresh overflow beats the clear made by the test in the same cycle.
   wire tb_flag_next = tick.tb_ovf | (tb_flag_reg & ~do_skt);

   assign skip_next = (do_skt & tb_flag_reg) | do_retsk ? 1'b1 :
                      skip_eat ? 1'b0 : skip_reg;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Second bytes are walked through even when skipped; a skipped indirect
   // opcode never enters the indirect state and so costs one cycle.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_FETCH: begin
            if (instr_end & two_byte) begin
               state_next = ST_OPERAND;
            end else if (do_jid | do_table_load_op) begin
               state_next = ST_INDIRECT;
            end
         end
         ST_OPERAND: begin
            if (instr_end) begin
               state_next = ST_FETCH;
            end
         end
         ST_INDIRECT: begin
            if (instr_end) begin
               state_next = ST_FETCH;
            end
         end
         default: begin
            state_next = ST_FETCH;
         end
      endcase
   end

   // Control registers that move only at the end of an instruction cycle.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg     <= ST_FETCH;
         pc_reg        <= `PC_RESET;
         fetch_reg     <= `PC_RESET;
         opc_reg       <= `OP_CLEAR_ACC_OP;
         table_load_op_mode_reg <= 1'b0;
      end else if (instr_end) begin
         state_reg     <= state_next;
         pc_reg        <= pc_next;
         fetch_reg     <= fetch_next;
         opc_reg       <= data_byte;
         table_load_op_mode_reg <= do_table_load_op;
      end
   end

   // Return stack: a push shifts older levels down, a pop shifts them up and
   // leaves the bottom level in place, which is how table-load copies B to C.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sa_reg <= `PC_RESET;
         sb_reg <= `PC_RESET;
         sc_reg <= `PC_RESET;
      end else if (do_push) begin
         sa_reg <= pc_inc;
         sb_reg <= sa_reg;
         sc_reg <= sb_reg;
      end else if (do_pop) begin
         sa_reg <= sb_reg;
         sb_reg <= sc_reg;
      end
   end

   // Working registers of the special instructions.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         acc_reg     <= `NIB_RESET;
         en_reg      <= `NIB_RESET;
         sio_reg     <= `NIB_RESET;
         q_reg       <= 8'h00;
         skl_reg     <= 1'b0;
         tb_flag_reg <= 1'b0;
         skip_reg    <= 1'b0;
      end else begin
         acc_reg     <= acc_next;
         sio_reg     <= sio_next;
         tb_flag_reg <= tb_flag_next;
         skip_reg    <= skip_next;
         if (do_lei) begin
            en_reg <= data_byte[3:0];
         end
         if (table_load_op_end) begin
            q_reg <= data_byte;
         end
         if (do_xas) begin
            skl_reg <= carry_i;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Outputs are registered; the strobe lags the phase by one clock, which
   // still leaves the memory most of the half cycle to drive its data.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         addr_phase_reg <= 1'b0;
         sk_reg         <= 1'b0;
         so_reg         <= 1'b0;
      end else begin
         addr_phase_reg <= tick.first_half;
         sk_reg         <= shift_md ? (skl_reg & tick.first_half) : skl_reg;
         so_reg         <= shift_md & sio_reg[3];
      end
   end

   edge_latch #(
      .LINES (2)
   ) u_edge (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .level_i  ({in_s2[3], in_s2[0]}),
      .clear_i  (do_read_edge_latches_op),
      .latch_o  (il_w)
   );

   assign rom_ad_o          = fetch_reg[7:0];
   assign rom_ad_oe_o       = addr_phase_reg;
   assign addr_phase_o      = addr_phase_reg;
   assign rom_addr_hi_o     = fetch_reg[10:8];
   assign so_o              = so_reg;
   assign logic_clock_out_o = sk_reg;
   assign acc_o             = acc_reg;
   assign enable_o          = en_reg;
   assign q_o               = q_reg;
   assign program_counter_o = pc_reg;
   assign skip_o            = skip_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_jid_done;
      instr_end && in_ind && !table_load_op_mode_reg;
   endsequence

   sequence s_table_load_op_done;
      instr_end && in_ind && table_load_op_mode_reg;
   endsequence

   a_lei_load : assert property (
      do_lei |=> en_reg == $past(data_byte[3:0])) else $error("enable register not loaded");
   a_xas_swap : assert property (
      do_xas |=> acc_reg == $past(sio_reg) && sio_reg == $past(acc_reg)) else $error("swap lost data");
   a_xas_clock : assert property (
      do_xas |=> skl_reg == $past(carry_i)) else $error("clock latch not updated");
   a_jid_cycles : assert property (
      do_jid |-> ##32 s_jid_done ##1 in_fetch) else $error("indirect jump not two cycles");
   a_jid_target : assert property (
      jid_end |=> $stable(pc_reg[10:8]) && pc_reg[7:0] == $past(data_byte)) else $error("bad jump target");
   a_read_edge_latches_op_value : assert property (
      do_read_edge_latches_op |=> acc_reg[2:1] == `READ_EDGE_LATCHES_OP_FILL && acc_reg[3] == $past(il_w[1])) else $error("latch read wrong");
   a_table_load_op_stack : assert property (
      do_table_load_op ##32 s_table_load_op_done |=> sc_reg == $past(sb_reg, 33) && sa_reg == $past(sa_reg, 33))
      else $error("table load stack wrong");
   a_table_load_op_cycles : assert property (
      do_table_load_op |-> ##32 s_table_load_op_done ##1 (in_fetch && pc_reg == $past(sa_reg))) else $error("table load timing");
   a_skt_skip : assert property (
      do_skt && tb_flag_reg && !tick.tb_ovf |=> skip_reg && !tb_flag_reg) else $error("timer skip failed");
   a_skip_short : assert property (
      instr_end && in_fetch && skip_reg && data_byte == `OP_JID |=> in_fetch && !skip_reg)
      else $error("skipped indirect jump too long");
   a_addr_drive : assert property (
      tick.first_half && instr_end == 1'b0 |=> rom_ad_oe_o && rom_ad_o == fetch_reg[7:0])
      else $error("address not driven in strobe");
endmodule : special_instruction_unit

// ---- sic_cfg.svh ----
/*
 * Constants of the special instruction unit: opcodes, field positions,
 * reset values and timing counts.
 * Assumes that it is included by its bare name from every design file.
 */
// Contract
// - Load-enable copies its 4-bit immediate into the function-enable register.
// - Accumulator-swap exchanges accumulator with serial shift/counter register.
// - Accumulator-swap also updates the logic clock output per enable setting.
// - Indirect jump loads counter bits 7:0 from the store byte at {pc hi, A, M}.
// - Indirect jump takes exactly 2 instruction cycles when executed.
// - Edge latches set when their line falls and stays low two instruction times.
// - Latch-read puts line-3 latch in A3, line-0 latch in A0, clears both.
// - Latch-read always writes zero to A1 and one to A2.
// - Edge latches keep their state through reset.
// - Table-load pushes, reads byte at {pc hi, A, M} into Q, then pops.
// - Table-load leaves old second stack level in third level.
// - Table-load takes two instruction cycles when executed.
// - A 10-bit time base divides instruction clock by 1024, flags each wrap.
// - Timer-skip skips next instruction and clears flag when set.
// - Instruction clock is the oscillator divided by 32.
// - Skipped bytes take one cycle each; skipped indirect jump or table-load one.
// - Store is 32 pages of 64 words; counter counts across pages.
// - Paging jumps and indirect accesses in a page's last word use the next page.
// - During address strobe device drives low address bits, memory drivers off.
// - After strobe memory drives data; upper three address bits on own outputs.
// - Return stack holds three 11-bit levels, pushed on call, popped on return.
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH
`define DIV_RATIO     32
`define TB_WIDTH      10
`define IL_MIN_INSTR  2
`define PC_RESET      11'h000
`define NIB_RESET     4'h0
`define OP_CLEAR_ACC_OP       8'h00
`define OP_SKT        8'h41
`define OP_RET        8'h48
`define OP_RETSK      8'h49
`define OP_XAS        8'h4f
`define OP_TABLE_LOAD_OP       8'hbf
`define OP_JID        8'hff
`define OP_PFX_IO     8'h33
`define OP_PFX_RAM    8'h23
`define OP_JMP_HI     4'h6
`define OP_SUBPAGE_CALL_OP_HI    2'h2
`define OP_JP_HI      2'h3
`define OP2_READ_INPUTS_OP      8'h28
`define OP2_READ_EDGE_LATCHES_OP      8'h29
`define OP2_LEI_HI    4'h6
`define SUBPAGE_HI    5'h02
`define TWIN_PAGE_HI  4'h1
`define READ_EDGE_LATCHES_OP_FILL     2'h2
`define EN_SHIFT_BIT  0
`endif

// ---- sic_pkg.sv ----
/*
 * Types shared by the special instruction unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sic_pkg;
   typedef enum logic [1:0] {ST_FETCH, ST_OPERAND, ST_INDIRECT} core_state_e;
   typedef logic [10:0] rom_addr_t;
   typedef logic [3:0]  nibble_t;
endpackage : sic_pkg

// ---- tick_if.sv ----
/*
 * Instruction-rate timing carried from the time-base generator to the core.
 * Assumes both ends run on the same oscillator clock.
 */
`timescale 1ns/1ps
interface tick_if;
   logic instr_end;
   logic first_half;
   logic tb_ovf;
   modport src (output instr_end, first_half, tb_ovf);
   modport snk (input instr_end, first_half, tb_ovf);
endinterface : tick_if

// ---- timebase_gen.sv ----
/*
 * Oscillator divider giving the instruction-cycle enable, and the
 * free-running time-base counter that flags each wrap.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "sic_cfg.svh"
module timebase_gen #(
   parameter int DIV      = `DIV_RATIO,
   parameter int TB_WIDTH = `TB_WIDTH
) (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   tick_if.src       tick
);
   import sic_pkg::*;
   localparam int            PW   = $clog2(DIV);
   localparam logic [PW-1:0] LAST = PW'(DIV - 1);
   localparam logic [PW-1:0] HALF = PW'(DIV / 2);

   logic [PW-1:0]       phase_reg;
   logic [TB_WIDTH-1:0] tb_reg;
   wire                 last_phase = (phase_reg == LAST);

   // Phase counter and time base; the time base steps once per instruction.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         phase_reg <= '0;
         tb_reg    <= '0;
      end else begin
         phase_reg <= last_phase ? '0 : phase_reg + 1'b1;
         if (last_phase) begin
            tb_reg <= tb_reg + 1'b1;
         end
      end
   end

   // Rate outputs are pure decodes of the phase and the time base, so they never drift apart.
   assign tick.instr_end  = last_phase;
   assign tick.first_half = (phase_reg < HALF);
   assign tick.tb_ovf     = last_phase & (&tb_reg);

   a_instr_period : assert property (@(posedge clk_i) disable iff (!resetn_i)
      tick.instr_end |-> ##32 tick.instr_end) else $error("instruction period not 32 clocks");
   a_tb_wraps : assert property (@(posedge clk_i) disable iff (!resetn_i)
      tick.tb_ovf |=> tb_reg == '0 && !tick.tb_ovf) else $error("time base did not wrap");
endmodule : timebase_gen

// ---- edge_latch.sv ----
/*
 * Falling-edge latches with a minimum-low filter, one per watched line.
 * Assumes level_i is already synchronised to clk_i.
 */
`timescale 1ns/1ps
`include "sic_cfg.svh"
module edge_latch #(
   parameter int LINES    = 2,
   parameter int MIN_CLKS = `IL_MIN_INSTR * `DIV_RATIO
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic [LINES-1:0] level_i,
   input  wire logic             clear_i,
   output logic      [LINES-1:0] latch_o
);
   localparam int            CW       = $clog2(MIN_CLKS);
   localparam logic [CW-1:0] CNT_LAST = CW'(MIN_CLKS - 1);

   for (genvar i = 0; i < LINES; i++) begin : g_line
      logic [CW-1:0] low_cnt_reg;
      logic          armed_reg;
      // Power-up value only, not a reset: a reset must leave the latch alone.
      logic          latch_reg = 1'b0;
      wire           fire = armed_reg & ~level_i[i] & (low_cnt_reg == CNT_LAST);

      // Counting every clock of the low level rejects anything shorter than the minimum.
      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            low_cnt_reg <= '0;
            armed_reg   <= 1'b0;
         end else if (level_i[i]) begin
            low_cnt_reg <= '0;
            armed_reg   <= 1'b1;
         end else if (armed_reg) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
            armed_reg   <= ~fire;
         end
      end

      // The latch has no reset on purpose; a new edge beats a clear.
      always_ff @(posedge clk_i) begin
         if (fire) begin
            latch_reg <= 1'b1;
         end else if (clear_i) begin
            latch_reg <= 1'b0;
         end
      end
      assign latch_o[i] = latch_reg;

      a_latch_set : assert property (@(posedge clk_i) disable iff (!resetn_i)
         fire |-> $past(!level_i[i], 63) ##1 latch_reg) else $error("edge latch failed to set");
   end
endmodule : edge_latch

// ---- rom_model.sv ----
/*
 * Behavioural external program store with its low-address latch.
 * Assumes the core shares one 8-bit port and strobes the address phase.
 */
`timescale 1ns/1ps
module rom_model (
   input  wire logic       addr_phase_i,
   input  wire logic       port_oe_i,
   input  wire logic [7:0] port_out_i,
   input  wire logic [2:0] addr_hi_i,
   output logic      [7:0] port_in_o
);
   // ----------------------------------------
   // Storage and address latch
   // ----------------------------------------
   logic [7:0] mem [0:2047];
   logic [7:0] addr_lat;

   // The latch is transparent while the strobe is high and holds after it.
   always_latch begin
      if (addr_phase_i) addr_lat = port_out_i;
   end

   // Port level: the core owns it during the strobe, the memory after it.
   assign port_in_o = port_oe_i ? port_out_i : mem[{addr_hi_i, addr_lat}];
endmodule : rom_model

// ---- special_instruction_unit_test.sv ----
/*
 * Self-checking bench: runs a short program from the store model.
 * Assumes the design's header, package and store model are compiled first.
 */
`timescale 1ns/1ps
`include "sic_cfg.svh"
module special_instruction_unit_test;
   import sic_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic       clk_i, resetn_i, oe, strobe, skip_o, sk_out;
   logic [3:0] in_pins_i;
   wire  [7:0] bus_in;
   logic [7:0] bus_out, q_o;
   logic [2:0] hi;
   nibble_t    acc_o, enable_o;
   rom_addr_t  program_counter_o;
   int         mismatches, cmp_count, cyc, t0, t_rel;
   logic [18:0] prog [18] = '{{11'h000, `OP_CLEAR_ACC_OP}, {11'h001, `OP_PFX_IO}, {11'h002, 8'h6a},
      {11'h003, `OP_PFX_IO}, {11'h004, `OP2_READ_EDGE_LATCHES_OP}, {11'h009, `OP_PFX_IO}, {11'h00a, `OP2_READ_EDGE_LATCHES_OP},
      {11'h00b, `OP_XAS}, {11'h00c, `OP_XAS}, {11'h00d, `OP_JID}, {11'h0c5, 8'h40},
      {11'h040, `OP_TABLE_LOAD_OP}, {11'h041, `OP_SKT}, {11'h042, 8'hc1}, {11'h043, 8'h60},
      {11'h044, 8'hff}, {11'h0ff, 8'hc5}, {11'h105, 8'hc5}};

   special_instruction_unit dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .rom_ad_i(bus_in),
      .rom_ad_o(bus_out), .rom_ad_oe_o(oe), .addr_phase_o(strobe), .rom_addr_hi_o(hi),
      .in_pins_i(in_pins_i), .si_i(1'b0), .so_o(), .logic_clock_out_o(sk_out),
      .ram_operand_i(4'h5), .carry_i(1'b1), .acc_o(acc_o), .enable_o(enable_o), .q_o(q_o),
      .program_counter_o(program_counter_o), .skip_o(skip_o));
   rom_model rom_u (.addr_phase_i(strobe), .port_oe_i(oe), .port_out_i(bus_out),
      .addr_hi_i(hi), .port_in_o(bus_in));

   // ----------------------------------------
   // Clock, cycle count and tasks
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc <= cyc + 1;

   task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Durations are plain counts, so a window is allowed where phase is loose.
   task automatic chk_time(input int got, input int lo, input int hi_t, input string what);
      cmp_count++;
      if (got < lo || got > hi_t) begin
         mismatches++;
         $display("[FAIL] %0t %s took %0d clocks", $time, what, got);
      end
   endtask : chk_time

   // Waits for a counter value, or for the skip flag when sk is set.
   task automatic wait_for(input rom_addr_t a, input bit sk);
      int k;
      k = 0;
      while (sk ? skip_o !== 1'b1 : program_counter_o !== a) begin
         @(negedge clk_i);
         k++;
         if (k > 40000) begin
            mismatches++;
            $display("[FAIL] %0t wait for %h timed out", $time, a);
            results();
         end
      end
      cmp_count++;
   endtask : wait_for

   task automatic results;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn_i = 1'b0;
      in_pins_i = 4'hf;
      for (int i = 0; i < 2048; i++) rom_u.mem[i] = 8'h44;
      foreach (prog[i]) rom_u.mem[prog[i][18:8]] = prog[i][7:0];
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_rel = cyc;
      wait_for(11'h003, 0); chk(enable_o, 4'ha, "enable");
      wait_for(11'h005, 0); chk(acc_o[2:1], 2'b10, "fill bits");
      // Line 3 stays low long; line 0 dips for less than two instruction times.
      @(posedge clk_i) in_pins_i <= 4'b0110;
      repeat (30) @(posedge clk_i);
      in_pins_i <= 4'b0111;
      wait_for(11'h00b, 0); chk(acc_o, 4'hc, "edge latches");
      wait_for(11'h00c, 0); chk(acc_o, 4'h0, "swap out");
      wait_for(11'h00d, 0); chk(acc_o, 4'hc, "swap back");
      t0 = cyc;
      // The pin register lags the clock latch by one clock.
      @(negedge clk_i);
      chk(sk_out, 1'b1, "clock latch");
      wait_for(11'h040, 0); chk_time(cyc - t0, 64, 64, "indirect jump");
      t0 = cyc;
      wait_for(11'h041, 0); chk(q_o, 11'h040, "table byte");
      chk_time(cyc - t0, 64, 64, "table load");
      wait_for(11'h000, 1); chk_time(cyc - t_rel, 32768, 32864, "time base");
      t0 = cyc;
      wait_for(11'h043, 0); chk_time(cyc - t0, 32, 32, "skipped jump");
      chk(skip_o, 1'b0, "skip done");
      wait_for(11'h105, 0); chk(program_counter_o, 11'h105, "page end jump");
      results();
   end
endmodule : special_instruction_unit_test
